/* File: hdl/vib_detect_consts.svh */
`ifndef VIB_DETECT_CONSTS_SVH
`define VIB_DETECT_CONSTS_SVH
`define ADDR_ACTION 16'h0185
`define ADDR_SENS 16'h0186
`define ADDR_THRESH 16'h0187
`define ADDR_INIT_CTRL 16'h0188
`define ADDR_IRQ_STATUS 16'h0189
`define ADDR_IRQ_MASK 16'h018A
`define ADDR_CODE 16'h018B
`define ADDR_PEAK 16'h018C
`define RESET_ACTION 16'h0000
`define RESET_SENS 16'h0064
`define RESET_THRESH 16'h0032
`define SENS_MIN 16'h0032
`define SENS_MAX 16'h01F4
`define THRESH_MAX 16'h1388
`define ACTION_MAX 16'h0002
`define CODE_WARNING 16'h0208
`define CODE_ALARM 16'h038F
`define IRQ_BIT_WARN 0
`define IRQ_BIT_ALARM 1
`define IRQ_BIT_INIT 2
`define EVAL_PERIOD_US 100
`define CLK_MHZ 40
`define EVAL_CYCLES ((`EVAL_PERIOD_US) * (`CLK_MHZ))
`define INIT_WINDOWS 16'h0004 // Short learning run, trades averaging for a quick result
`endif

/* File: hdl/vib_detect_pkg.sv */
package vib_detect_pkg;
  // Initialization sequencer states
  typedef enum logic [1:0] {
    init_idle,
    init_measure,
    init_write
  } init_state_type;
endpackage : vib_detect_pkg

/* File: hdl/vibration_detect_monitor.sv */
`include "vib_detect_consts.svh"
module vibration_detect_monitor
  import vib_detect_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] speed_i,
  input wire logic speed_valid_i,
  output logic vibration_warning_o,
  output logic vibration_alarm_o,
  output logic [15:0] fault_code_o,
  output logic irq_o
);

  // Whole block state in one record
  typedef struct packed {
    logic [15:0] action;
    logic [15:0] sens;
    logic [15:0] thresh;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    init_state_type init_state;
    logic [15:0] init_count;
    logic [15:0] init_peak;
    logic [15:0] prev_speed;
    logic [15:0] smin;
    logic [15:0] smax;
    logic [15:0] last_swing;
    logic [15:0] eval_count;
    logic warn;
    logic alarm;
    logic [15:0] code;
    logic [31:0] rdata;
    logic ack;
    logic waitreq; // Registered waitrequest, high while no answer stands
    logic irq;
  } state_type;

  localparam logic [15:0] EVAL_LAST = 16'(`EVAL_CYCLES - 1);

  state_type r;
  state_type next_r;

  // Swing scaled by 100 against threshold scaled by sensitivity
  logic [31:0] swing_scaled;
  logic [31:0] limit_scaled;
  logic window_end;
  logic vib_hit;
  logic [15:0] swing_now;
  logic set_warn; // Detection that raises the warning this cycle
  logic set_alarm; // Detection that raises the alarm this cycle

  always_comb
  begin
    swing_now = r.smax - r.smin;
    window_end = (r.eval_count == EVAL_LAST);
    swing_scaled = 32'(swing_now) * 32'h00000064;
    limit_scaled = 32'(r.thresh) * 32'(r.sens);
    // Strict exceed, so threshold zero still ignores a flat speed
    vib_hit = window_end && (swing_scaled > limit_scaled);
    set_warn = vib_hit && (r.init_state == init_idle) && (r.action[1:0] == 2'h1);
    set_alarm = vib_hit && (r.init_state == init_idle) && (r.action[1:0] == 2'h2);
  end

  // Next state: bus, detection, init sequencer, interrupts
  always_comb
  begin
    next_r = r;
    next_r.ack = 1'b0;
    // Track min and max of feedback speed in each window
    if (speed_valid_i)
    begin
      next_r.prev_speed = speed_i;
      if (speed_i > r.smax)
      begin
        next_r.smax = speed_i;
      end
      if (speed_i < r.smin)
      begin
        next_r.smin = speed_i;
      end
    end
    // Evaluation window tick
    if (window_end)
    begin
      next_r.eval_count = 16'h0000;
      next_r.last_swing = swing_now;
      next_r.smin = r.prev_speed;
      next_r.smax = r.prev_speed;
    end
    else
    begin
      next_r.eval_count = r.eval_count + 16'h0001;
    end
    // Report according to the action option
    if (vib_hit && r.init_state == init_idle)
    begin
      unique case (r.action[1:0])
        2'h1:
        begin
          next_r.warn = 1'b1;
          next_r.code = `CODE_WARNING;
          next_r.irq_status[`IRQ_BIT_WARN] = 1'b1;
        end
        2'h2:
        begin
          next_r.alarm = 1'b1;
          next_r.code = `CODE_ALARM;
          next_r.irq_status[`IRQ_BIT_ALARM] = 1'b1;
        end
        default:
        begin
          // Detection disabled
        end
      endcase
    end
    // Option zero drops any standing indication at once
    if (r.action[1:0] == 2'h0)
    begin
      next_r.warn = 1'b0;
      next_r.alarm = 1'b0;
      next_r.code = 16'h0000;
    end
    // Init sequencer: learn peak swing then write threshold
    unique case (r.init_state)
      init_idle:
      begin
      end
      init_measure:
      begin
        if (window_end)
        begin
          if (swing_now > r.init_peak)
          begin
            next_r.init_peak = swing_now;
          end
          next_r.init_count = r.init_count + 16'h0001;
          if (r.init_count == `INIT_WINDOWS - 16'h0001)
          begin
            next_r.init_state = init_write;
          end
        end
      end
      init_write:
      begin
        // Clamp learned value to threshold range
        next_r.thresh = (r.init_peak > `THRESH_MAX) ? `THRESH_MAX : r.init_peak;
        next_r.irq_status[`IRQ_BIT_INIT] = 1'b1;
        next_r.init_state = init_idle;
      end
    endcase
    // Completion edge: waitrequest is low here, so the write lands now
    if ((avs_read_i || avs_write_i) && r.ack)
    begin
      if (avs_write_i)
      begin
        unique case (avs_address_i)
          `ADDR_ACTION:
          begin
            // Out of range options are refused
            if (avs_writedata_i[15:0] <= `ACTION_MAX)
            begin
              next_r.action = avs_writedata_i[15:0];
            end
          end
          `ADDR_SENS:
          begin
            if (avs_writedata_i[15:0] >= `SENS_MIN && avs_writedata_i[15:0] <= `SENS_MAX)
            begin
              next_r.sens = avs_writedata_i[15:0];
            end
          end
          `ADDR_THRESH:
          begin
            if (avs_writedata_i[15:0] <= `THRESH_MAX)
            begin
              next_r.thresh = avs_writedata_i[15:0];
            end
          end
          `ADDR_INIT_CTRL:
          begin
            // Bit0 starts the learning run, bit1 clears warning and alarm
            if (avs_writedata_i[0] && r.init_state == init_idle)
            begin
              next_r.init_state = init_measure;
              next_r.init_count = 16'h0000;
              next_r.init_peak = 16'h0000;
            end
            if (avs_writedata_i[1])
            begin
              // A detection in this same cycle still wins over the clear
              next_r.warn = set_warn;
              next_r.alarm = set_alarm;
              next_r.code = set_warn ? `CODE_WARNING : (set_alarm ? `CODE_ALARM : 16'h0000);
            end
          end
          `ADDR_IRQ_MASK:
          begin
            next_r.irq_mask = avs_writedata_i[2:0];
          end
          default:
          begin
            // Unmapped or read-only: write ignored
          end
        endcase
      end
      else if (avs_address_i == `ADDR_IRQ_STATUS)
      begin
        // Clear only the bits handed out; an event in this cycle survives only on a bit that was clear
        next_r.irq_status = (r.irq_status & ~r.rdata[2:0]) | (next_r.irq_status & ~r.irq_status);
      end
    end
    // First edge: take the request and latch read data for the completion edge
    if ((avs_read_i || avs_write_i) && !r.ack)
    begin
      next_r.ack = 1'b1;
      next_r.rdata = 32'h00000000;
      if (avs_read_i)
      begin
        unique case (avs_address_i)
          `ADDR_ACTION: next_r.rdata = {16'h0000, r.action};
          `ADDR_SENS: next_r.rdata = {16'h0000, r.sens};
          `ADDR_THRESH: next_r.rdata = {16'h0000, r.thresh};
          `ADDR_INIT_CTRL: next_r.rdata = {30'h00000000, r.init_state != init_idle, 1'b0};
          `ADDR_IRQ_STATUS: next_r.rdata = {29'h00000000, r.irq_status};
          `ADDR_IRQ_MASK: next_r.rdata = {29'h00000000, r.irq_mask};
          `ADDR_CODE: next_r.rdata = {16'h0000, r.code};
          `ADDR_PEAK: next_r.rdata = {16'h0000, r.last_swing};
          default: next_r.rdata = 32'h00000000;
        endcase
      end
    end
    next_r.waitreq = !next_r.ack;
    next_r.irq = |(next_r.irq_status & next_r.irq_mask);
  end

  // Register the whole state, synchronous reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r <= '0;
      r.action <= `RESET_ACTION;
      r.sens <= `RESET_SENS;
      r.thresh <= `RESET_THRESH;
      r.init_state <= init_idle;
      r.smin <= 16'hFFFF;
      r.waitreq <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign vibration_warning_o = r.warn;
  assign vibration_alarm_o = r.alarm;
  assign fault_code_o = r.code;
  assign irq_o = r.irq;

  // Warning reported only under option 1
  property p_warn_option;
    @(posedge clk_i) disable iff (reset_i)
      (vib_hit && r.init_state == init_idle && r.action == 16'h0001) |=> (vibration_warning_o && fault_code_o == 16'h0208);
  endproperty
  a_warn_option: assert property (p_warn_option) else $error("warning not raised");

  // Alarm reported only under option 2
  property p_alarm_option;
    @(posedge clk_i) disable iff (reset_i)
      (vib_hit && r.init_state == init_idle && r.action == 16'h0002) |=> (vibration_alarm_o && fault_code_o == 16'h038F);
  endproperty
  a_alarm_option: assert property (p_alarm_option) else $error("alarm not raised");

  // Option zero never reports
  property p_disabled;
    @(posedge clk_i) disable iff (reset_i)
      (r.action == 16'h0000) |=> (!vibration_warning_o && !vibration_alarm_o);
  endproperty
  a_disabled: assert property (p_disabled) else $error("report while disabled");

  // Sensitivity stays within its range
  property p_sens_range;
    @(posedge clk_i) disable iff (reset_i)
      (r.sens >= 16'h0032 && r.sens <= 16'h01F4);
  endproperty
  a_sens_range: assert property (p_sens_range) else $error("sensitivity out of range");

  // Threshold stays within its range
  property p_thresh_range;
    @(posedge clk_i) disable iff (reset_i)
      (r.thresh <= 16'h1388);
  endproperty
  a_thresh_range: assert property (p_thresh_range) else $error("threshold out of range");

  // Learning ends by returning to idle with the init status bit set
  sequence s_write;
    r.init_state == init_write;
  endsequence
  property p_init_write;
    @(posedge clk_i) disable iff (reset_i)
      s_write |=> (r.init_state == init_idle && r.irq_status[2]);
  endproperty
  a_init_write: assert property (p_init_write) else $error("init write missed");

  // Window resets the evaluation counter
  property p_window;
    @(posedge clk_i) disable iff (reset_i)
      window_end |=> (r.eval_count == 16'h0000 && r.last_swing == $past(swing_now));
  endproperty
  a_window: assert property (p_window) else $error("window not evaluated");

  // Window verdict agrees with swing above threshold times sensitivity percent
  property p_detect;
    @(posedge clk_i) disable iff (reset_i)
      window_end |-> (vib_hit == (32'(r.smax - r.smin) > (32'(r.thresh) * 32'(r.sens)) / 32'h00000064));
  endproperty
  a_detect: assert property (p_detect) else $error("false detection");

  // Every request is answered after exactly one wait state
  property p_bus_answer;
    @(posedge clk_i) disable iff (reset_i)
      ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("request not answered");

  // A warning status bit holds until a completed status read hands it out
  property p_status_sticky;
    @(posedge clk_i) disable iff (reset_i)
      (r.irq_status[`IRQ_BIT_WARN] && !(avs_read_i && r.ack && avs_address_i == `ADDR_IRQ_STATUS))
        |=> r.irq_status[`IRQ_BIT_WARN];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

endmodule : vibration_detect_monitor

/* File: tb/speed_feedback_model.sv */
module speed_feedback_model
(
  input wire logic clk_i,
  input wire logic [15:0] base_i,
  input wire logic [15:0] swing_i,
  output logic [15:0] speed_o = 16'h0000,
  output logic valid_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase = 1'b0; // Low or high half of the ripple
  // Encoder sample every cycle; ripple of swing_i rpm rides on the base speed
  always @(posedge clk_i)
  begin
    phase <= !phase;
    speed_o <= phase ? base_i + swing_i : base_i;
    valid_o <= 1'b1;
  end
endmodule : speed_feedback_model

/* File: tb/vibration_detect_monitor_tb.sv */
`include "vib_detect_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module vibration_detect_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] avs_address_i = 16'h0000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o, rd;
  logic avs_waitrequest_o, speed_valid_i, vibration_warning_o, vibration_alarm_o, irq_o;
  logic [15:0] speed_i, fault_code_o;
  logic [15:0] base = 16'h03E8; // Base speed (low half of the ripple), picked at random
  logic [15:0] swing = 16'h0000; // Ripple amplitude
  int err_total = 0;
  int n_tests = 0;
  int seed = 94;
  int act = 0, sens = 100, thr = 50; // Register model
  int st; // Expected event: 1 warning, 2 alarm
  int n_wait = 0; // Cycles spent waiting for the end of learning
  // Rows: option, sensitivity, threshold, mask; last row sits exactly on the limit
  int tab[5][4] = '{'{0, 100, 50, 7}, '{1, 100, 50, 7}, '{2, 100, 50, 0}, '{1, 500, 50, 7}, '{2, 100, 100, 7}};
  always #12.5 clk_i = !clk_i;
  vibration_detect_monitor vibration_detect_monitor_inst (.clk_i(clk_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .speed_i(speed_i), .speed_valid_i(speed_valid_i), .vibration_warning_o(vibration_warning_o),
    .vibration_alarm_o(vibration_alarm_o), .fault_code_o(fault_code_o), .irq_o(irq_o));
  speed_feedback_model speed_feedback_model_inst (.clk_i(clk_i), .base_i(base), .swing_i(swing),
    .speed_o(speed_i), .valid_o(speed_valid_i));
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [15:0] a, input int d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= 32'(d);
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        err_total++;
        $display("ERROR %0t bus hang", $time);
        complete_run();
      end
      @(posedge clk_i);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // Idle edge so the next request is a fresh one
    @(posedge clk_i);
  endtask : bus
  // Write that the model accepts only inside the legal ranges
  task automatic wr(input logic [15:0] a, input int v);
    bus(1'b1, a, v);
    if (a == `ADDR_ACTION && v <= 2) act = v;
    if (a == `ADDR_SENS && v >= 50 && v <= 500) sens = v;
    if (a == `ADDR_THRESH && v <= 5000) thr = v;
  endtask : wr
  // Read back all three settings against the model
  task automatic regs();
    bus(1'b0, `ADDR_ACTION, 0);
    `CHK(rd, 32'(act))
    bus(1'b0, `ADDR_SENS, 0);
    `CHK(rd, 32'(sens))
    bus(1'b0, `ADDR_THRESH, 0);
    `CHK(rd, 32'(thr))
  endtask : regs
  // Main sequence
  initial
  begin
    base <= 16'($unsigned($random(seed)) % 3000 + 500);
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    regs();
    // Out-of-range values are dropped, boundaries kept
    wr(`ADDR_ACTION, 3);
    wr(`ADDR_SENS, 49);
    wr(`ADDR_SENS, 501);
    wr(`ADDR_THRESH, 5001);
    regs();
    wr(`ADDR_SENS, 50);
    wr(`ADDR_THRESH, 5000);
    regs();
    bus(1'b0, 16'h0200, 0);
    `CHK(rd, 32'h00000000)
    for (int i = 0; i < 5; i++)
    begin
      wr(`ADDR_ACTION, tab[i][0]);
      wr(`ADDR_SENS, tab[i][1]);
      wr(`ADDR_THRESH, tab[i][2]);
      bus(1'b1, `ADDR_IRQ_MASK, tab[i][3]);
      bus(1'b1, `ADDR_INIT_CTRL, 2);
      bus(1'b0, `ADDR_IRQ_STATUS, 0);
      swing <= 16'h0064;
      // Two whole windows plus margin
      repeat (8010) @(posedge clk_i);
      st = (act != 0 && 100 * 100 > thr * sens) ? act : 0;
      `CHK(vibration_warning_o, 1'(st == 1))
      `CHK(vibration_alarm_o, 1'(st == 2))
      `CHK(fault_code_o, 16'(st == 1 ? `CODE_WARNING : st == 2 ? `CODE_ALARM : 0))
      `CHK(irq_o, 1'((st & tab[i][3]) != 0))
      // Quiet motor, then sticky status and read-clear
      swing <= 16'h0000;
      repeat (8010) @(posedge clk_i);
      `CHK(vibration_warning_o, 1'(st == 1))
      `CHK(vibration_alarm_o, 1'(st == 2))
      bus(1'b0, `ADDR_IRQ_STATUS, 0);
      `CHK(rd[2:0], 3'(st))
      bus(1'b0, `ADDR_IRQ_STATUS, 0);
      `CHK(rd[2:0], 3'h0)
      `CHK(irq_o, 1'b0)
    end
    // Learning started with the motor running
    swing <= 16'h0064;
    bus(1'b1, `ADDR_INIT_CTRL, 1);
    bus(1'b0, `ADDR_INIT_CTRL, 0);
    `CHK(rd[1], 1'b1)
    // Done interrupt within the learning windows plus one partial window
    while (irq_o !== 1'b1 && n_wait < 20100)
    begin
      n_wait++;
      @(posedge clk_i);
    end
    `CHK(irq_o, 1'b1)
    // Learned threshold is the ripple amplitude that the model drives
    thr = 100;
    regs();
    bus(1'b0, `ADDR_IRQ_STATUS, 0);
    `CHK(rd[2:0], 3'h4)
    bus(1'b0, `ADDR_INIT_CTRL, 0);
    `CHK(rd[1], 1'b0)
    bus(1'b0, `ADDR_PEAK, 0);
    `CHK(rd, 32'h00000064)
    complete_run();
  end
endmodule : vibration_detect_monitor_tb
